// file: core/pfs_cfg.svh
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH

// ============================================================
// Register offsets (byte addresses)
`define PFS_P1_OFFS     8'h34
`define PFS_P2_OFFS     8'h38
`define PFS_P3_OFFS     8'h3c
`define PFS_P4_OFFS     8'h40
`define PFS_ADDR_W      8

// ============================================================
// Field positions
`define PFS_FUNC_LSB    0
`define PFS_ALT_LSB     8
`define PFS_TYPE_LSB    16
`define PFS_FIELD_W     8
`define PFS_DEF_W       24

// ============================================================
// Reset values
`define PFS_P1_RST      32'h0000_0000
`define PFS_P2_RST      32'h0000_0000
`define PFS_P3_RST      32'h0000_0000
`define PFS_P4_RST      32'h0000_00c0

`endif

// file: core/pfs_pin_decode.sv
`timescale 1ns/1ps

// Turns alt/func bit pairs into per-pin select codes
module pfs_pin_decode
  import pfs_pkg::*;
(
  input  wire logic [7:0]  alt_i,
  input  wire logic [7:0]  func_i,
  output pfs_sel_e [7:0]   sel_o
);

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      sel_o[i] = pfs_sel_e'({alt_i[i], func_i[i]});
    end
  end

endmodule : pfs_pin_decode

// file: core/pfs_pkg.sv
package pfs_pkg;

  // Pin function per select code {alt, func}
  typedef enum logic [1:0] {
    PFS_SEL_GPIO,
    PFS_SEL_ALT1,
    PFS_SEL_ALT2,
    PFS_SEL_ALT3
  } pfs_sel_e;

  // One port control register, defined fields only
  typedef struct packed {
    logic [7:0] schmitt;
    logic [7:0] alt;
    logic [7:0] func;
  } pfs_port_s;

endpackage : pfs_pkg

// file: core/pfs_port_func_sel.sv
// Contract
// RQ1 - Pin function from alternate and function bit pair; 00 is GPIO.
// RQ2 - Bits [23:16] enable Schmitt input per pin; one means enabled.
// RQ3 - Port1 pin4: 01 analog in 4, 10 SPI0 select, 11 comparator0 negative.
// RQ4 - Port1 pins 3,2: 01 analog in, 10 UART1 tx/rx, 11 reserved.
// RQ5 - Port1 pins 1,0: 01 analog, 10 timer3/timer2, 11 bus write strobes.
// RQ6 - Port2 pins: 01 bus address/data 15..8, 10 PWM B/A channels.
// RQ7 - Port2 code 11: pin6 comparator1 out, pins5,4 I2C1 enhanced only.
// RQ8 - Port3 pin7 01 read strobe; pin6 write strobe, clock out, comparator0.
// RQ9 - Port3 pins5,4: timers, I2C0; pin5 code 11 clock out enhanced only.
// RQ10 - Port3 pins3,2 ext irq; pin3 bus clock, timer1 ext; pin2 timer0 ext.
// RQ11 - Port3 pins1,0: UART0 tx/rx, 10 comparator1 inputs, 11 reserved.
// RQ12 - Port4 pins7,6: 01 debug data/clock; alternate bit set is reserved.
// RQ13 - Port4 pins5,4: bus latch/chip select, 10 I2C1 enhanced only.
// RQ14 - Port4 pin3 01 PWM2 ch3 output; capture when port4 function bit1 set.
// RQ15 - Port4 pin2 01 PWM ch2; pin1 PWM ch1 or timer3 ext input.
// RQ16 - Port4 register resets to 0xc0, debug pins active.
// RQ17 - Port2 and port3 registers reset to zero.
// RQ18 - Reserved bits [31:24] ignore writes and read as zero.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "pfs_cfg.svh"

module pfs_port_func_sel
  import pfs_pkg::*;
#(
  parameter bit ENHANCED = 1'b1
) (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  // Schmitt enables per port
  output logic [7:0]       port1_schmitt_enables_o,
  output logic [7:0]       port2_schmitt_enables_o,
  output logic [7:0]       port3_schmitt_enables_o,
  output logic [7:0]       port4_schmitt_enables_o,
  // Per-pin selects, 2 bits per pin: 0 GPIO, 1..3 alternates
  output logic [15:0]      port1_pin_sel_o,
  output logic [15:0]      port2_pin_sel_o,
  output logic [15:0]      port3_pin_sel_o,
  output logic [15:0]      port4_pin_sel_o,
  // Port 1 routing
  output logic [4:0]       analog_input_en_o,
  output logic             spi0_slave_select_en_o,
  output logic             comparator0_negative_input_en_o,
  output logic             uart1_tx_en_o,
  output logic             uart1_rx_en_o,
  output logic             timer3_pin_en_o,
  output logic             timer2_pin_en_o,
  output logic             bus_write_strobe_high_byte_en_o,
  output logic             bus_write_strobe_low_byte_en_o,
  // Port 2 routing
  output logic [7:0]       bus_addr_data_hi_en_o,
  output logic [3:0]       pwm_group_b_en_o,
  output logic [3:0]       pwm_group_a_en_o,
  output logic             comparator1_output_en_o,
  output logic             i2c1_data_p2_en_o,
  output logic             i2c1_clock_p2_en_o,
  // Port 3 routing
  output logic             bus_read_strobe_en_o,
  output logic             bus_write_strobe_en_o,
  output logic             clock_driver_output_p36_en_o,
  output logic             clock_driver_output_p35_en_o,
  output logic             comparator0_output_en_o,
  output logic             timer1_pin_en_o,
  output logic             timer0_pin_en_o,
  output logic             i2c0_clock_en_o,
  output logic             i2c0_data_en_o,
  output logic             external_interrupt_1_en_o,
  output logic             external_interrupt_0_en_o,
  output logic             bus_clock_en_o,
  output logic             timer1_external_input_en_o,
  output logic             timer0_external_input_en_o,
  output logic             uart0_tx_en_o,
  output logic             uart0_rx_en_o,
  output logic             comparator1_positive_input_en_o,
  output logic             comparator1_negative_input_en_o,
  // Port 4 routing
  output logic             debug_data_pin_en_o,
  output logic             debug_clock_pin_en_o,
  output logic             bus_addr_latch_en_o,
  output logic             bus_chip_select_en_o,
  output logic             i2c1_data_p4_en_o,
  output logic             i2c1_clock_p4_en_o,
  output logic             pwm2_ch3_output_en_o,
  output logic             pwm2_ch3_capture_en_o,
  output logic             pwm_ch2_en_o,
  output logic             pwm_ch1_en_o,
  output logic             timer3_external_input_en_o,
  // One flag per port: some pin holds a reserved code
  output logic [3:0]       reserved_sel_o
);

  // ============================================================
  // Helpers
  // Reserved upper byte reads zero
  function automatic logic [31:0] pfs_word(input pfs_port_s p);
    return {8'h00, p};
  endfunction : pfs_word

  // Select code compare
  function automatic logic is_sel(input pfs_sel_e s, input pfs_sel_e c);
    return s == c;
  endfunction : is_sel

  // ============================================================
  // Registers
  logic      wr_p1;
  logic      wr_p2;
  logic      wr_p3;
  logic      wr_p4;
  pfs_port_s port1_q;
  pfs_port_s port2_q;
  pfs_port_s port3_q;
  pfs_port_s port4_q;

  // RQ18 full address match
  assign wr_p1 = wr_i && (addr_i == `PFS_P1_OFFS);
  assign wr_p2 = wr_i && (addr_i == `PFS_P2_OFFS);
  assign wr_p3 = wr_i && (addr_i == `PFS_P3_OFFS);
  assign wr_p4 = wr_i && (addr_i == `PFS_P4_OFFS);

  // Clock enable gates every register
  pfs_port_reg #(.RST_VAL(`PFS_P1_RST)) u_p1 (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .clk_en_i   (clk_en_i),
    .wr_i       (wr_p1),
    .wdata_i    (wdata_i),
    .value_o    (port1_q)
  );
  // RQ17 zero reset
  pfs_port_reg #(.RST_VAL(`PFS_P2_RST)) u_p2 (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .clk_en_i   (clk_en_i),
    .wr_i       (wr_p2),
    .wdata_i    (wdata_i),
    .value_o    (port2_q)
  );
  pfs_port_reg #(.RST_VAL(`PFS_P3_RST)) u_p3 (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .clk_en_i   (clk_en_i),
    .wr_i       (wr_p3),
    .wdata_i    (wdata_i),
    .value_o    (port3_q)
  );
  // RQ16 debug reset
  pfs_port_reg #(.RST_VAL(`PFS_P4_RST)) u_p4 (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .clk_en_i   (clk_en_i),
    .wr_i       (wr_p4),
    .wdata_i    (wdata_i),
    .value_o    (port4_q)
  );

  // ============================================================
  // Read data register
  typedef struct packed {
    logic [31:0] rdata;
  } pfs_rd_state_s;

  pfs_rd_state_s state_q;
  pfs_rd_state_s state_d;

  always_comb begin
    state_d = state_q;
    if (rd_i) begin
      // RQ18 reserved read zero
      unique case (addr_i)
        `PFS_P1_OFFS: state_d.rdata = pfs_word(port1_q);
        `PFS_P2_OFFS: state_d.rdata = pfs_word(port2_q);
        `PFS_P3_OFFS: state_d.rdata = pfs_word(port3_q);
        `PFS_P4_OFFS: state_d.rdata = pfs_word(port4_q);
        default:      state_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data holds until next read
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= '0;
    end else if (clk_en_i) begin
      state_q <= state_d;
    end
  end

  assign rdata_o = state_q.rdata;

  // ============================================================
  // Per-pin select decode
  pfs_sel_e [7:0] s1;
  pfs_sel_e [7:0] s2;
  pfs_sel_e [7:0] s3;
  pfs_sel_e [7:0] s4;

  // RQ1 pair decode
  pfs_pin_decode u_d1 (.alt_i(port1_q.alt), .func_i(port1_q.func),
                       .sel_o(s1));
  pfs_pin_decode u_d2 (.alt_i(port2_q.alt), .func_i(port2_q.func),
                       .sel_o(s2));
  pfs_pin_decode u_d3 (.alt_i(port3_q.alt), .func_i(port3_q.func),
                       .sel_o(s3));
  pfs_pin_decode u_d4 (.alt_i(port4_q.alt), .func_i(port4_q.func),
                       .sel_o(s4));

  // RQ1 code outputs
  assign port1_pin_sel_o = s1;
  assign port2_pin_sel_o = s2;
  assign port3_pin_sel_o = s3;
  assign port4_pin_sel_o = s4;

  // RQ2 Schmitt enables
  assign port1_schmitt_enables_o = port1_q.schmitt;
  assign port2_schmitt_enables_o = port2_q.schmitt;
  assign port3_schmitt_enables_o = port3_q.schmitt;
  assign port4_schmitt_enables_o = port4_q.schmitt;

  // ============================================================
  // Port 1 (pins 4..0)
  // Pins 7..5 reach only the select outputs
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      analog_input_en_o[i] = is_sel(s1[i], PFS_SEL_ALT1);
    end
  end
  // RQ3 pin four
  assign spi0_slave_select_en_o          = is_sel(s1[4], PFS_SEL_ALT2);
  assign comparator0_negative_input_en_o = is_sel(s1[4], PFS_SEL_ALT3);
  // RQ4 UART1 pins
  assign uart1_tx_en_o = is_sel(s1[3], PFS_SEL_ALT2);
  assign uart1_rx_en_o = is_sel(s1[2], PFS_SEL_ALT2);
  // RQ5 timers, strobes
  assign timer3_pin_en_o = is_sel(s1[1], PFS_SEL_ALT2);
  assign timer2_pin_en_o = is_sel(s1[0], PFS_SEL_ALT2);
  assign bus_write_strobe_high_byte_en_o = is_sel(s1[1], PFS_SEL_ALT3);
  assign bus_write_strobe_low_byte_en_o  = is_sel(s1[0], PFS_SEL_ALT3);

  // ============================================================
  // Port 2
  // RQ6 bus and PWM
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      bus_addr_data_hi_en_o[i] = is_sel(s2[i], PFS_SEL_ALT1);
    end
    for (int i = 0; i < 4; i++) begin
      pwm_group_a_en_o[i] = is_sel(s2[i], PFS_SEL_ALT2);
      pwm_group_b_en_o[i] = is_sel(s2[i+4], PFS_SEL_ALT2);
    end
  end
  // RQ7 code three
  assign comparator1_output_en_o = is_sel(s2[6], PFS_SEL_ALT3);
  assign i2c1_data_p2_en_o  = ENHANCED && is_sel(s2[5], PFS_SEL_ALT3);
  assign i2c1_clock_p2_en_o = ENHANCED && is_sel(s2[4], PFS_SEL_ALT3);

  // ============================================================
  // Port 3
  // RQ8 strobes
  assign bus_read_strobe_en_o         = is_sel(s3[7], PFS_SEL_ALT1);
  assign bus_write_strobe_en_o        = is_sel(s3[6], PFS_SEL_ALT1);
  assign clock_driver_output_p36_en_o = is_sel(s3[6], PFS_SEL_ALT2);
  assign comparator0_output_en_o      = is_sel(s3[6], PFS_SEL_ALT3);
  // RQ9 timers, I2C0
  assign timer1_pin_en_o = is_sel(s3[5], PFS_SEL_ALT1);
  assign timer0_pin_en_o = is_sel(s3[4], PFS_SEL_ALT1);
  assign i2c0_clock_en_o = is_sel(s3[5], PFS_SEL_ALT2);
  assign i2c0_data_en_o  = is_sel(s3[4], PFS_SEL_ALT2);
  assign clock_driver_output_p35_en_o =
    ENHANCED && is_sel(s3[5], PFS_SEL_ALT3);
  // RQ10 interrupts
  assign external_interrupt_1_en_o  = is_sel(s3[3], PFS_SEL_ALT1);
  assign external_interrupt_0_en_o  = is_sel(s3[2], PFS_SEL_ALT1);
  assign bus_clock_en_o             = is_sel(s3[3], PFS_SEL_ALT2);
  assign timer1_external_input_en_o = is_sel(s3[3], PFS_SEL_ALT3);
  assign timer0_external_input_en_o = is_sel(s3[2], PFS_SEL_ALT2);
  // RQ11 UART0, comparator1
  assign uart0_tx_en_o = is_sel(s3[1], PFS_SEL_ALT1);
  assign uart0_rx_en_o = is_sel(s3[0], PFS_SEL_ALT1);
  assign comparator1_positive_input_en_o = is_sel(s3[1], PFS_SEL_ALT2);
  assign comparator1_negative_input_en_o = is_sel(s3[0], PFS_SEL_ALT2);

  // ============================================================
  // Port 4 (pins 7..1)
  // Pin 0 reaches only the select outputs
  // RQ12 debug pins
  assign debug_data_pin_en_o  = is_sel(s4[7], PFS_SEL_ALT1);
  assign debug_clock_pin_en_o = is_sel(s4[6], PFS_SEL_ALT1);
  // RQ13 bus, I2C1
  assign bus_addr_latch_en_o  = is_sel(s4[5], PFS_SEL_ALT1);
  assign bus_chip_select_en_o = is_sel(s4[4], PFS_SEL_ALT1);
  assign i2c1_data_p4_en_o  = ENHANCED && is_sel(s4[5], PFS_SEL_ALT2);
  assign i2c1_clock_p4_en_o = ENHANCED && is_sel(s4[4], PFS_SEL_ALT2);
  // RQ14 output or capture
  assign pwm2_ch3_output_en_o  = is_sel(s4[3], PFS_SEL_ALT1) &&
                                 !port4_q.func[1];
  assign pwm2_ch3_capture_en_o = is_sel(s4[3], PFS_SEL_ALT1) &&
                                 port4_q.func[1];
  // RQ15 PWM, timer3
  assign pwm_ch2_en_o = is_sel(s4[2], PFS_SEL_ALT1);
  assign pwm_ch1_en_o = is_sel(s4[1], PFS_SEL_ALT1);
  assign timer3_external_input_en_o = is_sel(s4[1], PFS_SEL_ALT2);

  // ============================================================
  // Reserved code detection
  always_comb begin
    // RQ4 port1 code 11
    reserved_sel_o[0] = is_sel(s1[3], PFS_SEL_ALT3) ||
                        is_sel(s1[2], PFS_SEL_ALT3);
    // RQ7 port2 code 11
    reserved_sel_o[1] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i != 6 && !(ENHANCED && (i == 4 || i == 5))) begin
        reserved_sel_o[1] = reserved_sel_o[1] ||
                            is_sel(s2[i], PFS_SEL_ALT3);
      end
    end
    // RQ8 port3 reserved codes
    reserved_sel_o[2] = port3_q.alt[7] ||
                        (!ENHANCED && is_sel(s3[5], PFS_SEL_ALT3)) ||
                        is_sel(s3[4], PFS_SEL_ALT3) ||
                        is_sel(s3[2], PFS_SEL_ALT3) ||
                        is_sel(s3[1], PFS_SEL_ALT3) ||
                        is_sel(s3[0], PFS_SEL_ALT3);
    // RQ12 port4 reserved codes
    reserved_sel_o[3] = port4_q.alt[7] || port4_q.alt[6] ||
                        port4_q.alt[3] || port4_q.alt[2] ||
                        is_sel(s4[5], PFS_SEL_ALT3) ||
                        is_sel(s4[4], PFS_SEL_ALT3) ||
                        is_sel(s4[1], PFS_SEL_ALT3) ||
                        (!ENHANCED && (is_sel(s4[5], PFS_SEL_ALT2) ||
                                       is_sel(s4[4], PFS_SEL_ALT2)));
  end

endmodule : pfs_port_func_sel

// file: core/pfs_port_reg.sv
`timescale 1ns/1ps
`include "pfs_cfg.svh"

// One port control register with reset value and write port
module pfs_port_reg
  import pfs_pkg::*;
#(
  parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  input  wire logic        wr_i,
  input  wire logic [31:0] wdata_i,
  output pfs_port_s        value_o
);

  typedef struct packed {
    pfs_port_s port;
  } pfs_reg_state_s;

  pfs_reg_state_s state_q;
  pfs_reg_state_s state_d;

  always_comb begin
    state_d = state_q;
    // Upper bits are dropped
    if (wr_i) begin
      state_d.port = wdata_i[`PFS_DEF_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= RST_VAL[`PFS_DEF_W-1:0];
    end else if (clk_en_i) begin
      state_q <= state_d;
    end
  end

  assign value_o = state_q.port;

endmodule : pfs_port_reg

// file: dv/pfs_port_func_sel_assertions.sv
`timescale 1ns/1ps
`include "pfs_cfg.svh"

// ============================================================
// Checker on the top-level ports
module pfs_port_func_sel_assertions
  import pfs_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        clk_en_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [7:0]  port2_schmitt_enables_o,
  input wire logic [15:0] port1_pin_sel_o,
  input wire logic [15:0] port2_pin_sel_o,
  input wire logic [15:0] port4_pin_sel_o,
  input wire logic [4:0]  analog_input_en_o,
  input wire logic        bus_write_strobe_high_byte_en_o,
  input wire logic [3:0]  pwm_group_b_en_o,
  input wire logic        comparator1_output_en_o,
  input wire logic [3:0]  reserved_sel_o,
  input wire logic        debug_data_pin_en_o,
  input wire logic        pwm2_ch3_capture_en_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_pin_code;
    wr_i && clk_en_i && addr_i == `PFS_P1_OFFS |=>
      port1_pin_sel_o[1:0] == {$past(wdata_i[8]), $past(wdata_i[0])};
  endproperty
  a_pin_code: assert property (p_pin_code)
    else $error("pin code does not follow written bits");

  property p_schmitt;
    wr_i && clk_en_i && addr_i == `PFS_P2_OFFS |=>
      port2_schmitt_enables_o == $past(wdata_i[23:16]);
  endproperty
  a_schmitt: assert property (p_schmitt)
    else $error("schmitt enables not taken from write");

  property p_rsv_read;
    rd_i && clk_en_i |=> rdata_o[31:24] == 8'h00;
  endproperty
  a_rsv_read: assert property (p_rsv_read)
    else $error("upper read bits not zero");

  property p_unmapped;
    rd_i && clk_en_i && !(addr_i inside {`PFS_P1_OFFS, `PFS_P2_OFFS,
      `PFS_P3_OFFS, `PFS_P4_OFFS}) |=> rdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_p4_reset;
    $past(sys_rst_i) |-> port4_pin_sel_o == 16'h5000;
  endproperty
  a_p4_reset: assert property (p_p4_reset)
    else $error("port4 pins not at reset codes");

  property p_analog_input_4;
    analog_input_en_o[4] == (port1_pin_sel_o[9:8] == 2'h1);
  endproperty
  a_analog_input_4: assert property (p_analog_input_4)
    else $error("analog input 4 routing wrong");

  property p_wrh;
    bus_write_strobe_high_byte_en_o == (port1_pin_sel_o[3:2] == 2'h3);
  endproperty
  a_wrh: assert property (p_wrh)
    else $error("high byte strobe routing wrong");

  property p_pwmb;
    pwm_group_b_en_o[3] == (port2_pin_sel_o[15:14] == 2'h2);
  endproperty
  a_pwmb: assert property (p_pwmb)
    else $error("pwm group b routing wrong");

  property p_cmp1;
    comparator1_output_en_o == (port2_pin_sel_o[13:12] == 2'h3);
  endproperty
  a_cmp1: assert property (p_cmp1)
    else $error("comparator1 output routing wrong");

  property p_dbg;
    debug_data_pin_en_o == (port4_pin_sel_o[15:14] == 2'h1);
  endproperty
  a_dbg: assert property (p_dbg)
    else $error("debug data routing wrong");

  property p_rsv4;
    port4_pin_sel_o[15] |-> reserved_sel_o[3];
  endproperty
  a_rsv4: assert property (p_rsv4)
    else $error("port4 reserved flag missing");

  property p_cap;
    pwm2_ch3_capture_en_o ==
      (port4_pin_sel_o[7:6] == 2'h1 && port4_pin_sel_o[2]);
  endproperty
  a_cap: assert property (p_cap)
    else $error("capture routing wrong");
endmodule : pfs_port_func_sel_assertions

bind pfs_port_func_sel pfs_port_func_sel_assertions u_chk (.*);

// file: dv/testbench.sv
`timescale 1ns/1ps
`include "pfs_cfg.svh"

module testbench;
  import pfs_pkg::*;
`define CHK(g, e) check(32'(g), 32'(e))

  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1;
  logic wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, rd_v;
  logic [7:0]  port1_schmitt_enables_o, port2_schmitt_enables_o;
  logic [7:0]  port3_schmitt_enables_o, port4_schmitt_enables_o;
  logic [15:0] port1_pin_sel_o, port2_pin_sel_o;
  logic [15:0] port3_pin_sel_o, port4_pin_sel_o;
  logic [4:0]  analog_input_en_o;
  logic [7:0]  bus_addr_data_hi_en_o;
  logic [3:0]  pwm_group_b_en_o, pwm_group_a_en_o, reserved_sel_o;
  logic spi0_slave_select_en_o, comparator0_negative_input_en_o;
  logic uart1_tx_en_o, uart1_rx_en_o, timer3_pin_en_o, timer2_pin_en_o;
  logic bus_write_strobe_high_byte_en_o, bus_write_strobe_low_byte_en_o;
  logic comparator1_output_en_o, i2c1_data_p2_en_o, i2c1_clock_p2_en_o;
  logic bus_read_strobe_en_o, bus_write_strobe_en_o;
  logic clock_driver_output_p36_en_o, clock_driver_output_p35_en_o;
  logic comparator0_output_en_o, timer1_pin_en_o, timer0_pin_en_o;
  logic i2c0_clock_en_o, i2c0_data_en_o, bus_clock_en_o;
  logic external_interrupt_1_en_o, external_interrupt_0_en_o;
  logic timer1_external_input_en_o, timer0_external_input_en_o;
  logic uart0_tx_en_o, uart0_rx_en_o;
  logic comparator1_positive_input_en_o, comparator1_negative_input_en_o;
  logic debug_data_pin_en_o, debug_clock_pin_en_o, bus_addr_latch_en_o;
  logic bus_chip_select_en_o, i2c1_data_p4_en_o, i2c1_clock_p4_en_o;
  logic pwm2_ch3_output_en_o, pwm2_ch3_capture_en_o, pwm_ch2_en_o;
  logic pwm_ch1_en_o, timer3_external_input_en_o;
  int   fails = 0, cmp_count = 0, cycles = 0;
  logic [1:0] k;

  pfs_port_func_sel #(.ENHANCED(1'b1)) dut (.*);

  always #4 core_clk_i = ~core_clk_i;

  // ============================================================
  // Bus and compare helpers
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  task automatic set_code(input logic [7:0] a, input logic [1:0] c);
    wr(a, {16'h0000, {8{c[1]}}, {8{c[0]}}});
  endtask : set_code

  // ============================================================
  // Scenarios
  task automatic test_reset();
    rd(`PFS_P2_OFFS, rd_v); `CHK(rd_v, 32'h0);
    rd(`PFS_P3_OFFS, rd_v); `CHK(rd_v, 32'h0);
    rd(`PFS_P4_OFFS, rd_v); `CHK(rd_v, 32'h0000_00c0);
    `CHK({debug_data_pin_en_o, debug_clock_pin_en_o}, 2'h3);
    $display("test reset done");
  endtask : test_reset

  task automatic test_rw();
    wr(`PFS_P2_OFFS, 32'hffff_ffff);
    wr(`PFS_P3_OFFS, 32'hab5a_c33c);
    rd(`PFS_P2_OFFS, rd_v); `CHK(rd_v, 32'h00ff_ffff);
    rd(`PFS_P3_OFFS, rd_v); `CHK(rd_v, 32'h005a_c33c);
    `CHK({port2_schmitt_enables_o, port3_schmitt_enables_o}, 16'hff5a);
    wr(`PFS_P1_OFFS, 32'h00a5_0000);
    wr(`PFS_P4_OFFS, 32'h003c_00c0);
    rd(`PFS_P1_OFFS, rd_v); `CHK(rd_v, 32'h00a5_0000);
    `CHK({port1_schmitt_enables_o, port4_schmitt_enables_o}, 16'ha53c);
    wr(8'h44, 32'hffff_ffff);
    rd(8'h44, rd_v); `CHK(rd_v, 32'h0);
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    wr(`PFS_P3_OFFS, 32'h0000_0000);
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    rd(`PFS_P3_OFFS, rd_v); `CHK(rd_v, 32'h005a_c33c);
    $display("test register access done");
  endtask : test_rw

  task automatic test_port1();
    for (int c = 0; c < 4; c++) begin
      k = c[1:0];
      set_code(`PFS_P1_OFFS, k);
      `CHK(port1_pin_sel_o, {8{k}});
      `CHK(analog_input_en_o, (k == 2'h1) ? 5'h1f : 5'h00);
      `CHK({spi0_slave_select_en_o, comparator0_negative_input_en_o},
           {k == 2'h2, k == 2'h3});
      `CHK({uart1_tx_en_o, uart1_rx_en_o, reserved_sel_o[0]},
           {{2{k == 2'h2}}, k == 2'h3});
      `CHK({timer3_pin_en_o, timer2_pin_en_o, bus_write_strobe_high_byte_en_o,
            bus_write_strobe_low_byte_en_o},
           {{2{k == 2'h2}}, {2{k == 2'h3}}});
    end
    $display("test port1 done");
  endtask : test_port1

  task automatic test_port2();
    for (int c = 0; c < 4; c++) begin
      k = c[1:0];
      set_code(`PFS_P2_OFFS, k);
      `CHK(port2_pin_sel_o, {8{k}});
      `CHK(bus_addr_data_hi_en_o, {8{k == 2'h1}});
      `CHK({pwm_group_b_en_o, pwm_group_a_en_o}, {8{k == 2'h2}});
      `CHK({comparator1_output_en_o, i2c1_data_p2_en_o, i2c1_clock_p2_en_o,
            reserved_sel_o[1]}, {4{k == 2'h3}});
    end
    $display("test port2 done");
  endtask : test_port2

  task automatic test_port3();
    for (int c = 0; c < 4; c++) begin
      k = c[1:0];
      set_code(`PFS_P3_OFFS, k);
      `CHK(port3_pin_sel_o, {8{k}});
      `CHK({bus_read_strobe_en_o, bus_write_strobe_en_o,
            clock_driver_output_p36_en_o, comparator0_output_en_o,
            reserved_sel_o[2]},
           {{2{k == 2'h1}}, k == 2'h2, k == 2'h3, k[1]});
      `CHK({timer1_pin_en_o, timer0_pin_en_o, i2c0_clock_en_o, i2c0_data_en_o,
            clock_driver_output_p35_en_o},
           {{2{k == 2'h1}}, {2{k == 2'h2}}, k == 2'h3});
      `CHK({external_interrupt_1_en_o, external_interrupt_0_en_o,
            bus_clock_en_o, timer1_external_input_en_o,
            timer0_external_input_en_o},
           {{2{k == 2'h1}}, k == 2'h2, k == 2'h3, k == 2'h2});
      `CHK({uart0_tx_en_o, uart0_rx_en_o, comparator1_positive_input_en_o,
            comparator1_negative_input_en_o},
           {{2{k == 2'h1}}, {2{k == 2'h2}}});
    end
    $display("test port3 done");
  endtask : test_port3

  task automatic test_port4();
    for (int c = 0; c < 4; c++) begin
      k = c[1:0];
      set_code(`PFS_P4_OFFS, k);
      `CHK(port4_pin_sel_o, {8{k}});
      `CHK({debug_data_pin_en_o, debug_clock_pin_en_o, reserved_sel_o[3]},
           {{2{k == 2'h1}}, k[1]});
      `CHK({bus_addr_latch_en_o, bus_chip_select_en_o, i2c1_data_p4_en_o,
            i2c1_clock_p4_en_o}, {{2{k == 2'h1}}, {2{k == 2'h2}}});
      `CHK({pwm2_ch3_output_en_o, pwm2_ch3_capture_en_o},
           {1'b0, k == 2'h1});
      `CHK({pwm_ch2_en_o, pwm_ch1_en_o, timer3_external_input_en_o},
           {{2{k == 2'h1}}, k == 2'h2});
    end
    wr(`PFS_P4_OFFS, 32'h0000_0008);
    `CHK({pwm2_ch3_output_en_o, pwm2_ch3_capture_en_o}, 2'h2);
    $display("test port4 done");
  endtask : test_port4

  // ============================================================
  // Verdict and hang guard
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    repeat (6) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    test_reset();
    test_rw();
    test_port1();
    test_port2();
    test_port3();
    test_port4();
    finish_test();
  end
endmodule : testbench
